// [ulms_defs.svh]
`ifndef ULMS_DEFS_SVH
`define ULMS_DEFS_SVH

// Register byte offsets on the APB bus
`define ULMS_OFS_DATA 8'h00
`define ULMS_OFS_IER 8'h04
`define ULMS_OFS_LFR 8'h08
`define ULMS_OFS_MCR 8'h0c
`define ULMS_OFS_LSR 8'h10
`define ULMS_OFS_MSR 8'h14
`define ULMS_OFS_EFR 8'h18

// Reset values
`define ULMS_LFR_RST 8'h00
`define ULMS_MCR_RST 8'h00
`define ULMS_IER_RST 8'h00
`define ULMS_EFR_RST 5'h00
`define ULMS_DIV_LO_RST 8'h01
`define ULMS_DIV_HI_RST 8'h00

// Line format fields
`define ULMS_LFR_PAR_EN 3
`define ULMS_LFR_EVEN 4
`define ULMS_LFR_FORCE 5
`define ULMS_LFR_BREAK 6
`define ULMS_LFR_DIV_SEL 7

// Modem control fields
`define ULMS_MCR_DTR 0
`define ULMS_MCR_RTS 1
`define ULMS_MCR_AUX1 2
`define ULMS_MCR_IRQ_OE 3
`define ULMS_MCR_LOOP 4
`define ULMS_MCR_XON_ANY 5
`define ULMS_MCR_IRDA 6
`define ULMS_MCR_PRESCALE 7

// Enhanced and interrupt enable fields
`define ULMS_EFR_ENH 4
`define ULMS_IER_RLS 2
`define ULMS_IER_MSI 3

// Timing counts
`define ULMS_PRESCALE_MAX 2'h3
`define ULMS_IR_PULSE_PHASES 4'h3
`define ULMS_IR_STRETCH 8'h40

`endif

// [ulms_far_modem.sv]
`timescale 1ns/100ps
`default_nettype none

module ulms_far_modem (
  // Clock and wanted line state, bit set means asserted
  input wire logic sys_clk,
  input wire logic [3:0] want,
  // Active-low modem lines and the serial line
  output logic clear_to_send_n = 1'b1,
  output logic set_ready_n = 1'b1,
  output logic modem_bell_in = 1'b1,
  output logic carrier_n = 1'b1,
  output logic serial_rx
);
  // Lines move just after an edge, unrelated to the block's sampling
  always @(posedge sys_clk) begin
    {carrier_n, modem_bell_in, set_ready_n, clear_to_send_n} <= ~want;
  end
  // No frames sent; line rests at mark
  assign serial_rx = 1'b1;
endmodule // ulms_far_modem

`default_nettype wire

// [ulms_line_modem.sv]
// Functional notes
// (R1) Forced parity: bit is 1 when even-select is 0, 0 when it is 1.
// (R2) Break bit holds the serial output low until software clears it.
// (R3) Top line format bit swaps data registers for divisor latch registers.
// (R4) Terminal-ready and send-request pins are the inverse of their bits; the code drives both high in loopback.
// (R5) In 16 mode interrupt pin floats only when select pin and enable are 0.
// (R6) Loopback routes enable bit to internal aux 2, reserved bit to ring.
// (R7) Xon-any, infrared and prescaler bits change only with enhanced enable.
// (R8) Xon-any resumes transmit on any character; flow characters are not stored.
// (R9) Infrared mode uses encoder and decoder; transmit idles low.
// (R10) Prescaler bit set divides the clock by four, else undivided.
// (R11) Line status interrupt: overrun at once, errors when character at head.
// (R12) Data ready is set while any received character is held.
// (R13) Character arriving with full FIFO sets overrun and is dropped.
// (R14) Parity and framing error bits describe the head character only.
// (R15) Break loads one character and holds indication until input high.
// (R16) Holding-empty flag follows an empty transmit holding stage.
// (R17) Transmitter-empty needs holding stage and shift register both empty.
// (R18) FIFO error flag set while any stored byte carries an error tag.
// (R19) Send-clear and set-ready deltas set on change, raise modem interrupt.
// (R20) Ring delta sets only on the end of ringing.
// (R21) Clear-to-send status is inverted pin, or send-request bit in loopback.
// (R22) Flow change indication is cleared by a modem status read.
// (R23) Modem status read clears deltas; line status read clears overrun.
`timescale 1ns/100ps
`default_nettype none
`include "ulms_defs.svh"

module ulms_line_modem #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the remote side, asynchronous
  input wire logic serial_rx,
  input wire logic clear_to_send_n,
  input wire logic set_ready_n,
  input wire logic modem_bell_in,
  input wire logic carrier_n,
  input wire logic irq_drive_select,
  input wire logic mode_68,
  // Pins to the remote side
  output logic serial_tx,
  output logic terminal_ready_n,
  output logic send_request_n,
  output logic irq_out,
  output logic irq_out_oe,
  // Receive datapath, same clock
  input wire logic rx_char_done,
  input wire logic rx_break_char,
  input wire logic rx_is_flow_char,
  input wire logic rx_fifo_full,
  input wire logic [6:0] rx_level,
  input wire logic [6:0] rx_err_count,
  input wire logic rx_head_parity_err,
  input wire logic rx_head_frame_err,
  input wire logic rx_head_break,
  input wire logic [7:0] rx_head_data,
  output logic rx_store,
  output logic rx_pop,
  output logic rx_line,
  // Transmit datapath, same clock
  input wire logic tx_bit,
  input wire logic [3:0] tx_bit_phase,
  input wire logic tx_halted,
  input wire logic [6:0] tx_level,
  input wire logic tx_shift_idle,
  input wire logic irq_other,
  output logic tx_load,
  output logic [7:0] tx_data,
  output logic tx_resume,
  // Format and clocking to the datapath
  input wire logic [7:0] par_data,
  output ulms_pkg::ulms_parity_t par_mode,
  output logic par_bit,
  output logic [7:0] divisor_lo,
  output logic [7:0] divisor_hi,
  output logic baud_clk_en,
  output logic flow_change
);
  import ulms_pkg::*;

  logic pready_q, pslverr_q, hit, acc, done, wr, rd;
  logic [31:0] prdata_q;
  logic [7:0] rd_data, lfr_q, mcr_q, ier_q, line_status, modem_status, div_lo_q, div_hi_q;
  logic [4:0] efr_q;
  logic [5:0] sync_m_q, sync_s_q;
  logic [3:0] st_q, cur, delta_q, delta_set;
  logic st_v_q, ovr_q, brk_hold_q, flow_chg_q, loop, ir;
  logic rx_store_q, rx_pop_q, rx_line_q, tx_load_q, tx_resume_q;
  logic [7:0] tx_data_q, ir_cnt_q;
  logic [1:0] pre_cnt_q;
  logic baud_en_q, serial_tx_q, dtr_n_q, rts_n_q, irq_q, irq_oe_q;
  ulms_parity_t par_mode_q, par_mode_d;
  logic par_bit_q;
  logic [7:0] par_mask;
  logic rd_lsr, rd_msr, rx_s, sel_s, rx_dec;

  assign loop = mcr_q[`ULMS_MCR_LOOP];
  assign ir = mcr_q[`ULMS_MCR_IRDA];
  // First access cycle captures read data; second one completes
  assign acc = psel & penable & ~pready_q;
  assign done = psel & penable & pready_q;
  assign wr = done & pwrite & pstrb[0] & ~pslverr_q;
  assign rd = done & ~pwrite & ~pslverr_q;
  assign rd_lsr = rd & (paddr == ADDR_W'(`ULMS_OFS_LSR));
  assign rd_msr = rd & (paddr == ADDR_W'(`ULMS_OFS_MSR));
  assign rx_s = sync_s_q[4];
  assign sel_s = sync_s_q[5];

  // Two-stage synchronisers for every asynchronous pin except mode_68
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_m_q <= 6'h3f;
      sync_s_q <= 6'h3f;
    end else begin
      sync_m_q <= {irq_drive_select, serial_rx, carrier_n, modem_bell_in, set_ready_n, clear_to_send_n};
      sync_s_q <= sync_m_q;
    end
  end

  // Register read mux; divisor latch shares two offsets
  always_comb begin
    hit = 1'b1;
    rd_data = 8'h00;
    case (paddr)
      ADDR_W'(`ULMS_OFS_DATA): rd_data = lfr_q[`ULMS_LFR_DIV_SEL] ? div_lo_q : rx_head_data; // R3
      ADDR_W'(`ULMS_OFS_IER): rd_data = lfr_q[`ULMS_LFR_DIV_SEL] ? div_hi_q : ier_q; // R3
      ADDR_W'(`ULMS_OFS_LFR): rd_data = lfr_q;
      ADDR_W'(`ULMS_OFS_MCR): rd_data = mcr_q;
      ADDR_W'(`ULMS_OFS_LSR): rd_data = line_status;
      ADDR_W'(`ULMS_OFS_MSR): rd_data = modem_status;
      ADDR_W'(`ULMS_OFS_EFR): rd_data = {3'h0, efr_q};
      default: hit = 1'b0;
    endcase
  end

  // APB answer: one wait state, error on unmapped offsets
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit;
      prdata_q <= acc ? {24'h0, rd_data} : 32'h0;
    end
  end

  // Software registers; enhanced bits locked unless enabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfr_q <= `ULMS_LFR_RST;
      mcr_q <= `ULMS_MCR_RST;
      ier_q <= `ULMS_IER_RST;
      efr_q <= `ULMS_EFR_RST;
      div_lo_q <= `ULMS_DIV_LO_RST;
      div_hi_q <= `ULMS_DIV_HI_RST;
    end else if (wr) begin
      case (paddr)
        ADDR_W'(`ULMS_OFS_DATA): if (lfr_q[`ULMS_LFR_DIV_SEL]) div_lo_q <= pwdata[7:0]; // R3
        ADDR_W'(`ULMS_OFS_IER): begin
          if (lfr_q[`ULMS_LFR_DIV_SEL]) div_hi_q <= pwdata[7:0]; // R3
          else ier_q <= efr_q[`ULMS_EFR_ENH] ? pwdata[7:0] : {ier_q[7:4], pwdata[3:0]};
        end
        ADDR_W'(`ULMS_OFS_LFR): lfr_q <= pwdata[7:0];
        ADDR_W'(`ULMS_OFS_MCR): mcr_q <= efr_q[`ULMS_EFR_ENH] ? pwdata[7:0] : {mcr_q[7:5], pwdata[4:0]}; // R7
        ADDR_W'(`ULMS_OFS_EFR): efr_q <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // Data window strobes toward the FIFOs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_load_q <= 1'b0;
      tx_data_q <= 8'h00;
      rx_pop_q <= 1'b0;
    end else begin
      tx_load_q <= wr & (paddr == ADDR_W'(`ULMS_OFS_DATA)) & ~lfr_q[`ULMS_LFR_DIV_SEL]; // R3
      if (wr) tx_data_q <= pwdata[7:0];
      rx_pop_q <= rd & (paddr == ADDR_W'(`ULMS_OFS_DATA)) & ~lfr_q[`ULMS_LFR_DIV_SEL]; // R3
    end
  end

  // Modem inputs, replaced by control bits in loopback
  always_comb begin
    if (loop) begin
      cur = {mcr_q[`ULMS_MCR_IRQ_OE], mcr_q[`ULMS_MCR_AUX1], mcr_q[`ULMS_MCR_DTR], mcr_q[`ULMS_MCR_RTS]}; // R6 R21
    end else begin
      cur = ~sync_s_q[3:0]; // R21
    end
    delta_set[0] = st_v_q & (st_q[0] ^ cur[0]); // R19
    delta_set[1] = st_v_q & (st_q[1] ^ cur[1]); // R19
    delta_set[2] = st_v_q & st_q[2] & ~cur[2]; // R20
    delta_set[3] = st_v_q & (st_q[3] ^ cur[3]);
  end
  assign modem_status = {cur, delta_q};

  // Delta flags; a set in the clearing cycle survives, unread bits survive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= 4'h0;
      st_v_q <= 1'b0;
      delta_q <= 4'h0;
      flow_chg_q <= 1'b0;
    end else begin
      st_q <= cur;
      st_v_q <= 1'b1;
      delta_q <= (delta_q & ~({4{rd_msr}} & prdata_q[3:0])) | delta_set; // R23
      if ((st_v_q & st_q[0] & ~cur[0]) | (~rts_n_q & ~mcr_q[`ULMS_MCR_RTS])) flow_chg_q <= 1'b1;
      else if (rd_msr) flow_chg_q <= 1'b0; // R22
    end
  end

  // Line status; parity and framing tags only for the head character; break also shows the break hold flag
  assign line_status = {rx_err_count != 7'h0, // R18
                (tx_level == 7'h0) & tx_shift_idle, // R17
                tx_level == 7'h0, // R16
                rx_head_break | brk_hold_q, // R15
                rx_head_frame_err, // R14
                rx_head_parity_err, // R14
                ovr_q,
                rx_level != 7'h0}; // R12

  // Overrun, break hold and receive store decisions
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovr_q <= 1'b0;
      brk_hold_q <= 1'b0;
      rx_store_q <= 1'b0;
      tx_resume_q <= 1'b0;
    end else begin
      if (rx_char_done & rx_fifo_full) ovr_q <= 1'b1; // R13
      else if (rd_lsr & prdata_q[1]) ovr_q <= 1'b0; // R23
      if (rx_char_done & rx_break_char) brk_hold_q <= 1'b1; // R15
      else if (rx_line_q) brk_hold_q <= 1'b0; // R15
      // Full FIFO drops the character so stored data stays intact
      rx_store_q <= rx_char_done & ~rx_fifo_full // R13
                    & ~(rx_break_char & brk_hold_q) // R15
                    & ~(rx_is_flow_char & (efr_q[3:0] != 4'h0)); // R8
      tx_resume_q <= rx_char_done & mcr_q[`ULMS_MCR_XON_ANY] & tx_halted; // R8
    end
  end

  // Interrupt level and three-state control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      irq_q <= (ier_q[`ULMS_IER_RLS] & (line_status[1] | line_status[2] | line_status[3] | line_status[4])) // R11
               | (ier_q[`ULMS_IER_MSI] & (delta_q != 4'h0)) // R19
               | irq_other;
      irq_oe_q <= mode_68 | sel_s | mcr_q[`ULMS_MCR_IRQ_OE]; // R5
    end
  end

  // Modem control pins idle high in loopback so the far end sees nothing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      dtr_n_q <= loop | ~mcr_q[`ULMS_MCR_DTR]; // R4
      rts_n_q <= loop | ~mcr_q[`ULMS_MCR_RTS]; // R4
    end
  end

  // Infrared decoder stretches each short pulse to a space level
  assign rx_dec = (ir_cnt_q == 8'h00);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ir_cnt_q <= 8'h00;
    end else if (rx_s) begin
      ir_cnt_q <= `ULMS_IR_STRETCH; // R9
    end else if (ir_cnt_q != 8'h00) begin
      ir_cnt_q <= ir_cnt_q - 8'h01;
    end
  end

  // Serial routing; break beats every other source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_tx_q <= 1'b1;
      rx_line_q <= 1'b1;
    end else begin
      if (lfr_q[`ULMS_LFR_BREAK]) serial_tx_q <= 1'b0; // R2
      else if (loop) serial_tx_q <= ~ir;
      else if (ir) serial_tx_q <= ~tx_bit & (tx_bit_phase < `ULMS_IR_PULSE_PHASES); // R9
      else serial_tx_q <= tx_bit;
      rx_line_q <= loop ? tx_bit : (ir ? rx_dec : rx_s); // R6 R9
    end
  end

  // Prescaler enable toward the baud generator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_cnt_q <= 2'h0;
      baud_en_q <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
      baud_en_q <= ~mcr_q[`ULMS_MCR_PRESCALE] | (pre_cnt_q == `ULMS_PRESCALE_MAX); // R10
    end
  end

  // Parity selection and generator, masked by word length
  assign par_mask = 8'hff >> (2'h3 - lfr_q[1:0]);
  always_comb begin
    case (lfr_q[`ULMS_LFR_FORCE:`ULMS_LFR_PAR_EN])
      3'b001: par_mode_d = ULMS_PAR_ODD;
      3'b011: par_mode_d = ULMS_PAR_EVEN;
      3'b101: par_mode_d = ULMS_PAR_MARK; // R1
      3'b111: par_mode_d = ULMS_PAR_SPACE; // R1
      default: par_mode_d = ULMS_PAR_NONE; // R1
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      par_mode_q <= ULMS_PAR_NONE;
      par_bit_q <= 1'b0;
    end else begin
      par_mode_q <= par_mode_d;
      case (par_mode_d)
        ULMS_PAR_ODD: par_bit_q <= ~^(par_data & par_mask);
        ULMS_PAR_EVEN: par_bit_q <= ^(par_data & par_mask);
        ULMS_PAR_MARK: par_bit_q <= 1'b1; // R1
        default: par_bit_q <= 1'b0; // R1
      endcase
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_tx = serial_tx_q;
  assign terminal_ready_n = dtr_n_q;
  assign send_request_n = rts_n_q;
  assign irq_out = irq_q;
  assign irq_out_oe = irq_oe_q;
  assign rx_store = rx_store_q;
  assign rx_pop = rx_pop_q;
  assign rx_line = rx_line_q;
  assign tx_load = tx_load_q;
  assign tx_data = tx_data_q;
  assign tx_resume = tx_resume_q;
  assign par_mode = par_mode_q;
  assign par_bit = par_bit_q;
  assign divisor_lo = div_lo_q;
  assign divisor_hi = div_hi_q;
  assign baud_clk_en = baud_en_q;
  assign flow_change = flow_chg_q;

endmodule // ulms_line_modem
`default_nettype wire

// [ulms_line_modem_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ulms_defs.svh"

module ulms_line_modem_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and datapath
  input wire logic irq_drive_select,
  input wire logic mode_68,
  input wire logic tx_bit,
  input wire logic serial_tx,
  input wire logic terminal_ready_n,
  input wire logic send_request_n,
  input wire logic irq_out_oe,
  input wire ulms_pkg::ulms_parity_t par_mode,
  input wire logic par_bit,
  input wire logic baud_clk_en
);
  import ulms_pkg::*;
  logic wr, ir_mode, brk_q, enh_q;
  logic [7:0] mcr_q;
  logic [2:0] quiet_q;
  // Shadow of completed writes, so the modes behind the pins are known
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  assign ir_mode = mcr_q[6] && !mcr_q[4] && !brk_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mcr_q <= 8'h00;
    end else if (wr && paddr == `ULMS_OFS_MCR) begin
      mcr_q <= enh_q ? pwdata[7:0] : {mcr_q[7:5], pwdata[4:0]};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      brk_q <= 1'b0;
    end else if (wr && paddr == `ULMS_OFS_LFR) begin
      brk_q <= pwdata[`ULMS_LFR_BREAK];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enh_q <= 1'b0;
    end else if (wr && paddr == `ULMS_OFS_EFR) begin
      enh_q <= pwdata[`ULMS_EFR_ENH];
    end
  end
  // Quiet cycles of every drive request; four covers the pin synchroniser
  always_ff @(posedge sys_clk) begin
    if (rst || mode_68 || irq_drive_select || mcr_q[3]) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_par;
    $stable(par_mode) && par_mode inside {ULMS_PAR_MARK, ULMS_PAR_SPACE} |-> par_bit == (par_mode == ULMS_PAR_MARK);
  endproperty
  a_par: assert property (p_par) else $error("forced parity bit wrong");
  property p_brk;
    brk_q && $past(brk_q) |-> !serial_tx;
  endproperty
  a_brk: assert property (p_brk) else $error("break not held low");
  property p_ir;
    ir_mode && $past(ir_mode) && $past(tx_bit) |-> !serial_tx;
  endproperty
  a_ir: assert property (p_ir) else $error("infrared idle not low");
  property p_pins;
    !mcr_q[4] && $stable(mcr_q) |-> {terminal_ready_n, send_request_n} == {!mcr_q[0], !mcr_q[1]};
  endproperty
  a_pins: assert property (p_pins) else $error("modem outputs wrong");
  property p_oe;
    quiet_q > 3'h3 |-> !irq_out_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("interrupt pin driven");
  property p_apb;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("bus answer timing wrong");
  property p_baud;
    mcr_q[7] && $past(mcr_q[7]) && baud_clk_en |=> (!baud_clk_en || !mcr_q[7]) [*3];
  endproperty
  a_baud: assert property (p_baud) else $error("prescaled enable too often");
  property p_loop;
    pready && !pwrite && paddr == `ULMS_OFS_MSR && mcr_q[4] |-> prdata[7:4] == {mcr_q[3:2], mcr_q[0], mcr_q[1]};
  endproperty
  a_loop: assert property (p_loop) else $error("loopback status wrong");
endmodule // ulms_line_modem_monitor

bind ulms_line_modem ulms_line_modem_monitor #(.ADDR_W(ADDR_W)) ulms_line_modem_monitor_i (.*);

`default_nettype wire

// [ulms_line_modem_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ulms_defs.svh"

module ulms_line_modem_tb;
  import ulms_pkg::*;
  // Bus and pins
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, par_data = 8'h00, rx_head_data = 8'h5a, tx_data, divisor_lo, divisor_hi;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'h0, want = 4'h0, tx_bit_phase = 4'h0;
  logic serial_rx, clear_to_send_n, set_ready_n, modem_bell_in, carrier_n, irq_drive_select = 1'b0, mode_68 = 1'b0;
  logic serial_tx, terminal_ready_n, send_request_n, irq_out, irq_out_oe;
  // Datapath stand-in
  logic rx_char_done = 1'b0, rx_break_char = 1'b0, rx_is_flow_char = 1'b0, rx_fifo_full = 1'b0;
  logic [6:0] rx_level = 7'h0, rx_err_count = 7'h0, tx_level = 7'h0;
  logic rx_head_parity_err = 1'b0, rx_head_frame_err = 1'b0, rx_head_break = 1'b0;
  logic rx_store, rx_pop, rx_line, tx_load, tx_resume, par_bit, baud_clk_en, flow_change;
  logic tx_bit = 1'b1, tx_halted = 1'b0, tx_shift_idle = 1'b1, irq_other = 1'b0;
  ulms_parity_t par_mode;
  int bad_count = 0, total_checks = 0, i, n;
  int loads = 0, pops = 0;
  logic [7:0] lf [5] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38};
  ulms_parity_t pm [5] = '{ULMS_PAR_NONE, ULMS_PAR_ODD, ULMS_PAR_EVEN, ULMS_PAR_MARK, ULMS_PAR_SPACE};
  logic [2:0] oe_v [4] = '{3'b000, 3'b001, 3'b100, 3'b010};
  logic [7:0] rx_cfg [3] = '{8'h01, 8'h7b, 8'ha4};
  logic [7:0] lsr_exp [3] = '{8'h60, 8'h8d, 8'hb1};

  ulms_line_modem #(.ADDR_W(8)) ulms_line_modem_i (.*);
  ulms_far_modem ulms_far_modem_i (.*);

  always #5 sys_clk = ~sys_clk;
  // Serial bits keep moving so the output path is exercised
  always @(posedge sys_clk) begin
    tx_bit <= ~tx_bit;
    tx_bit_phase <= tx_bit_phase + 4'h1;
  end
  // Count one-cycle strobes so none slips between the bus calls
  always @(posedge sys_clk) begin
    loads += int'(tx_load === 1'b1);
    pops += int'(rx_pop === 1'b1);
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer from just after an edge; two idle cycles let outputs settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      bad_count++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 4'h0);
    chk(q, {24'h0, exp});
  endtask

  // Completed character; strobes answer in the following cycle
  task automatic rx_pulse(input logic full);
    rx_fifo_full <= full;
    rx_char_done <= 1'b1;
    @(posedge sys_clk);
    rx_char_done <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic cnt_en();
    n = 0;
    repeat (8) begin
      @(posedge sys_clk);
      n += int'(baud_clk_en === 1'b1);
    end
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`ULMS_OFS_LFR, 8'h00);
    apb(1'b0, 8'h1c, 8'h00, 4'h0);
    chk(err, 1'b1);
    for (i = 0; i < 5; i++) begin
      wr8(`ULMS_OFS_LFR, lf[i]);
      chk(par_mode, pm[i]);
    end
    wr8(`ULMS_OFS_LFR, 8'h40);
    chk(serial_tx, 1'b0);
    wr8(`ULMS_OFS_LFR, 8'h80);
    wr8(`ULMS_OFS_DATA, 8'h34);
    wr8(`ULMS_OFS_IER, 8'h12);
    chk({divisor_hi, divisor_lo}, 16'h1234);
    wr8(`ULMS_OFS_LFR, 8'h00);
    chk(serial_tx, !tx_bit);
    rd(`ULMS_OFS_IER, 8'h00);
    // Data window: only the write with the latch deselected loads
    wr8(`ULMS_OFS_DATA, 8'ha5);
    chk(tx_data, 8'ha5);
    rd(`ULMS_OFS_DATA, 8'h5a);
    chk(loads, 1);
    chk(pops, 1);
    apb(1'b1, `ULMS_OFS_MCR, 8'h03, 4'h0);
    rd(`ULMS_OFS_MCR, 8'h00);
    wr8(`ULMS_OFS_MCR, 8'h01);
    chk({terminal_ready_n, send_request_n}, 2'b01);
    // Interrupt pin drive: select pin, 68 mode, enable bit
    for (i = 0; i < 4; i++) begin
      {irq_drive_select, mode_68} <= oe_v[i][2:1];
      wr8(`ULMS_OFS_MCR, {4'h0, oe_v[i][0], 3'h0});
      chk(irq_out_oe, |oe_v[i]);
    end
    // Enhanced bits stay locked until the enable is set
    wr8(`ULMS_OFS_MCR, 8'he0);
    rd(`ULMS_OFS_MCR, 8'h00);
    cnt_en();
    chk(n, 8);
    wr8(`ULMS_OFS_EFR, 8'h10);
    wr8(`ULMS_OFS_MCR, 8'he0);
    rd(`ULMS_OFS_MCR, 8'he0);
    cnt_en();
    chk(n, 2);
    tx_halted <= 1'b1;
    rx_pulse(1'b0);
    chk({tx_resume, rx_store}, 2'b11);
    wr8(`ULMS_OFS_MCR, 8'h1e);
    apb(1'b0, `ULMS_OFS_MSR, 8'h00, 4'h0);
    chk(q[7:4], 4'hd);
    chk({terminal_ready_n, send_request_n}, 2'b11);
    wr8(`ULMS_OFS_MCR, 8'h00);
    apb(1'b0, `ULMS_OFS_MSR, 8'h00, 4'h0);
    rd(`ULMS_OFS_MSR, 8'h00);
    // Modem line deltas, ring counted only at its end
    want <= 4'b0001;
    repeat (4) @(posedge sys_clk);
    rd(`ULMS_OFS_MSR, 8'h11);
    rd(`ULMS_OFS_MSR, 8'h10);
    want <= 4'b0110;
    // Partner edge, two sync stages, then the flag register
    repeat (5) @(posedge sys_clk);
    chk(flow_change, 1'b1);
    rd(`ULMS_OFS_MSR, 8'h63);
    chk(flow_change, 1'b0);
    want <= 4'b0000;
    repeat (4) @(posedge sys_clk);
    rd(`ULMS_OFS_MSR, 8'h06);
    // Overrun with a full store, then the status table
    wr8(`ULMS_OFS_IER, 8'h04);
    rx_pulse(1'b1);
    chk(rx_store, 1'b0);
    // Interrupt level follows the overrun flag one cycle later
    @(posedge sys_clk);
    chk(irq_out, 1'b1);
    rd(`ULMS_OFS_LSR, 8'h62);
    rd(`ULMS_OFS_LSR, 8'h60);
    chk(irq_out, 1'b0);
    for (i = 0; i < 3; i++) begin
      {rx_level[1:0], rx_err_count[0], rx_head_parity_err, rx_head_frame_err, rx_head_break, tx_level[0],
        tx_shift_idle} <= rx_cfg[i];
      rd(`ULMS_OFS_LSR, lsr_exp[i]);
    end
    finish_test();
  end
endmodule // ulms_line_modem_tb

`default_nettype wire

// [ulms_pkg.sv]
package ulms_pkg;

  // Parity selection seen by the serial datapath
  typedef enum logic [2:0] {
    ULMS_PAR_NONE = 3'h0,
    ULMS_PAR_ODD = 3'h1,
    ULMS_PAR_EVEN = 3'h3,
    ULMS_PAR_MARK = 3'h2,
    ULMS_PAR_SPACE = 3'h6
  } ulms_parity_t;

endpackage
